// *** dpcs_pkg.sv ***
// shared constants and types of the disk pack control status block
package dpcs_pkg;
	localparam int NUNITS = 8;
	localparam int UNITW  = 3;
	localparam int CYLW   = 8;
	localparam int HEADW  = 5;
	localparam int FMTW   = 9;
	localparam int MSIMW  = 6;
	localparam int LOCKW  = 3;
	localparam int DW     = 18;
	localparam int AW     = 8;

	// register byte addresses
	localparam logic [AW-1:0] ADDR_CTRL   = 8'h00;
	localparam logic [AW-1:0] ADDR_UNIT   = 8'h04;
	localparam logic [AW-1:0] ADDR_CYL    = 8'h08;
	localparam logic [AW-1:0] ADDR_HEAD   = 8'h0C;
	localparam logic [AW-1:0] ADDR_MAINT  = 8'h10;
	localparam logic [AW-1:0] ADDR_STATUS = 8'h14;
	localparam logic [AW-1:0] ADDR_ATTN   = 8'h18;
	localparam logic [AW-1:0] ADDR_SUCYL  = 8'h1C;
	localparam logic [AW-1:0] ADDR_FMTGEN = 8'h20;
	localparam logic [AW-1:0] ADDR_STATE  = 8'h24;

	// control register fields
	localparam int CTRL_FUNC_LSB = 0;
	localparam int CTRL_GO_BIT   = 3;
	localparam int CTRL_MNT_BIT  = 4;

	// maintenance simulation register fields
	localparam int MS_ONLINE = 0;
	localparam int MS_READY  = 1;
	localparam int MS_UNSAFE = 2;
	localparam int MS_RDONLY = 3;
	localparam int MS_ONCYL  = 4;
	localparam int MS_SPARE  = 5;

	// reset values
	localparam logic [UNITW-1:0] UNIT_RST  = 3'h0;
	localparam logic [CYLW-1:0]  CYL_RST   = 8'h00;
	localparam logic [HEADW-1:0] HEAD_RST  = 5'h00;
	localparam logic [MSIMW-1:0] MAINT_RST = 6'h00;
	localparam logic [FMTW-1:0]  FMT_RST   = 9'h000;

	// timing and geometry
	localparam int SEEK_TMO_MS   = 150;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SEEK_TMO_CYC  = SEEK_TMO_MS * 1000000 / CLK_PERIOD_NS;
	localparam int LAST_HEAD_DEF = 19;

	typedef enum logic [2:0] {
		FN_NOP         = 3'b000,
		FN_READ        = 3'b001,
		FN_WRITE       = 3'b010,
		FN_SEEK        = 3'b011,
		FN_RECALIBRATE = 3'b100,
		FN_WRITE_ALL   = 3'b101,
		FN_FORMAT      = 3'b110,
		FN_WRITE_CHECK = 3'b111
	} dpcs_func_t;

	typedef enum logic [2:0] {
		ST_IDLE          = 3'b000,
		ST_READ          = 3'b001,
		ST_WRITE         = 3'b010,
		ST_SEEK          = 3'b011,
		ST_ALL_HEADS_OFF = 3'b100,
		ST_INC_HEAD      = 3'b101,
		ST_RECALIBRATE   = 3'b110
	} dpcs_state_t;

	typedef struct packed {
		logic            online;
		logic            ready;
		logic            unsafe;
		logic            readOnly;
		logic            onCyl;
		logic [CYLW-1:0] cyl;
	} dpcs_drv_t;

	typedef struct packed {
		logic busy;
		logic attnFlag;
		logic maintModeBit;
		logic writeLockFlag;
		logic readOnlyFlag;
		logic seekUnderwayFlag;
		logic unitReadyFlag;
		logic unitOnlineFlag;
		logic driveUnsafeFlag;
		logic seekTimeoutFlag;
		logic packEndFlag;
	} dpcs_stat_t;

	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] wrData;
		logic          wr;
		logic          rd;
	} dpcs_req_t;
endpackage

// *** dpcs_unit_watch.sv ***
// seek watcher for one drive unit: underway, timeout and completion
`timescale 1ns/1ps
module dpcs_unit_watch #(
	parameter int TMO = dpcs_pkg::SEEK_TMO_CYC
) (
	// clock, reset, enable
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic ce,
	// seek request and drive position
	input  wire logic start,
	input  wire logic onCyl,
	// results
	output logic      underway,
	output logic      timedOut,
	output logic      done
);
	import dpcs_pkg::*;
	localparam int CW = $clog2(TMO + 1);

	logic [CW-1:0] cnt;
	logic          leftCyl;

	// completion only counts after the heads were seen off cylinder
	wire arrive = underway && leftCyl && onCyl;
	wire expire = underway && (cnt == CW'(TMO - 1));

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			underway <= 1'b0;
			timedOut <= 1'b0;
			done     <= 1'b0;
			cnt      <= '0;
			leftCyl  <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (start) begin
				underway <= 1'b1;
				timedOut <= 1'b0;
				cnt      <= '0;
				leftCyl  <= 1'b0;
			end else if (arrive) begin
				underway <= 1'b0;
				done     <= 1'b1;
			end else if (expire) begin
				underway <= 1'b0;
				timedOut <= 1'b1;
			end else if (underway) begin
				cnt <= cnt + CW'(1);
				if (!onCyl) begin
					leftCyl <= 1'b1;
				end
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	seek_starts_a: assert property (ce && start |=> underway && !timedOut)
		else $error("seek start did not mark the unit underway");
	seek_timeout_a: assert property (ce && expire && !start && !arrive |=> timedOut && !underway)
		else $error("seek timeout flag not raised at the limit");
	wait_bound_a: assert property (underway |-> cnt < CW'(TMO))
		else $error("seek wait ran past the timeout");
endmodule

// *** dpcs_ctrl.sv ***
// control sequencer, selected-unit status and register file of the disk pack control
`timescale 1ns/1ps
module dpcs_ctrl #(
	parameter int SEEK_TMO  = dpcs_pkg::SEEK_TMO_CYC,
	parameter int LAST_HEAD = dpcs_pkg::LAST_HEAD_DEF
) (
	// clock, reset, enable
	input  wire logic                                         clk_sys,
	input  wire logic                                         rst_n,
	input  wire logic                                         ce,
	// register port
	input  wire dpcs_pkg::dpcs_req_t                          busReq,
	output logic [dpcs_pkg::DW-1:0]                           busRdData,
	// drive status and switches
	input  wire dpcs_pkg::dpcs_drv_t [dpcs_pkg::NUNITS-1:0]   drvStat,
	input  wire logic                                         lockSwitch,
	input  wire logic [dpcs_pkg::LOCKW-1:0]                   lockUnitSel,
	input  wire logic [dpcs_pkg::LOCKW-1:0]                   lockCylLimit,
	// transfer events
	input  wire logic                                         headerFound,
	input  wire logic                                         wordTick,
	input  wire logic                                         trackEnd,
	input  wire logic                                         wcDone,
	// drive commands
	output logic [dpcs_pkg::NUNITS-1:0]                       seekStart,
	output logic [dpcs_pkg::NUNITS-1:0]                       recalibrateStart,
	output logic [dpcs_pkg::CYLW-1:0]                         seekCyl,
	output logic [dpcs_pkg::HEADW-1:0]                        headSel,
	output logic                                              headEnable,
	output logic                                              writeGate,
	// status
	output dpcs_pkg::dpcs_state_t                             ctrlState,
	output dpcs_pkg::dpcs_stat_t                              status,
	output logic [dpcs_pkg::NUNITS-1:0]                       unitAttentionBits,
	output logic [dpcs_pkg::CYLW-1:0]                         suCyl,
	output logic [dpcs_pkg::FMTW-1:0]                         fmtGen
);
	import dpcs_pkg::*;

	dpcs_state_t              state;
	dpcs_state_t              next_state;
	dpcs_func_t               funcReg;
	logic                     maintMode;
	logic [UNITW-1:0]         unitSel;
	logic [CYLW-1:0]          cylAddr;
	logic [HEADW-1:0]         headAddr;
	logic [MSIMW-1:0]         maintSimReg;
	logic                     ending;
	logic                     calPend;
	logic [DW-1:0]            rdMux;
	dpcs_drv_t [NUNITS-1:0]   effDrv;
	logic [NUNITS-1:0]        uw;
	logic [NUNITS-1:0]        tmo;
	logic [NUNITS-1:0]        seekDone;

	assign ctrlState = state;

	// address decode
	wire wrCtrl  = busReq.wr && (busReq.addr == ADDR_CTRL);
	wire wrUnit  = busReq.wr && (busReq.addr == ADDR_UNIT);
	wire wrCyl   = busReq.wr && (busReq.addr == ADDR_CYL);
	wire wrHead  = busReq.wr && (busReq.addr == ADDR_HEAD);
	wire wrMaint = busReq.wr && (busReq.addr == ADDR_MAINT);
	wire wrAttn  = busReq.wr && (busReq.addr == ADDR_ATTN);

	wire dpcs_func_t goFunc = dpcs_func_t'(busReq.wrData[CTRL_FUNC_LSB +: 3]);
	wire goWriteFn = (goFunc == FN_WRITE) || (goFunc == FN_WRITE_ALL) || (goFunc == FN_FORMAT);
	wire isWriteFn = (funcReg == FN_WRITE) || (funcReg == FN_WRITE_ALL) || (funcReg == FN_FORMAT);

	// selected unit view
	wire dpcs_drv_t selDrv = effDrv[unitSel];
	wire selUw  = uw[unitSel];
	wire selTmo = tmo[unitSel];
	wire [NUNITS-1:0] selOneHot = NUNITS'(1) << unitSel;

	wire lockHit = lockSwitch && (unitSel == lockUnitSel)
		&& (cylAddr <= {5'h00, lockCylLimit});

	// a write-type function on a protected unit is not started at all
	wire goRefuse = goWriteFn && (lockHit || selDrv.readOnly);
	wire goReq = wrCtrl && busReq.wrData[CTRL_GO_BIT] && (state == ST_IDLE) && !goRefuse;
	wire goSeek = goReq && (goFunc == FN_SEEK);
	wire goCal  = goReq && (goFunc == FN_RECALIBRATE);
	wire goXfer = goReq && (goFunc != FN_SEEK) && (goFunc != FN_RECALIBRATE)
		&& (goFunc != FN_NOP);
	wire lastHead = (headSel == HEAD_RST + HEADW'(LAST_HEAD));
	wire packEndSet = (state == ST_INC_HEAD) && lastHead && !wcDone;

	wire [NUNITS-1:0] attnClr = wrAttn ? busReq.wrData[NUNITS-1:0] : '0;
	// set wins over a clear landing in the same cycle
	wire [NUNITS-1:0] next_attn = (unitAttentionBits & ~attnClr) | seekDone;

	// maintenance register stands in for the selected drive
	always_comb begin
		for (int i = 0; i < NUNITS; i++) begin
			effDrv[i] = drvStat[i];
			if (maintMode && (unitSel == UNITW'(i))) begin
				effDrv[i].online   = maintSimReg[MS_ONLINE];
				effDrv[i].ready    = maintSimReg[MS_READY];
				effDrv[i].unsafe   = maintSimReg[MS_UNSAFE];
				effDrv[i].readOnly = maintSimReg[MS_RDONLY];
				effDrv[i].onCyl    = maintSimReg[MS_ONCYL];
				effDrv[i].cyl      = cylAddr;
			end
		end
	end

	for (genvar u = 0; u < NUNITS; u++) begin : g_unit
		dpcs_unit_watch #(
			.TMO(SEEK_TMO)
		) u_watch (
			.clk_sys  (clk_sys),
			.rst_n    (rst_n),
			.ce       (ce),
			.start    (seekStart[u] | recalibrateStart[u]),
			.onCyl    (effDrv[u].onCyl),
			.underway (uw[u]),
			.timedOut (tmo[u]),
			.done     (seekDone[u])
		);
	end

	// sequencer
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (goSeek) begin
					next_state = ST_SEEK;
				end else if (goCal) begin
					next_state = ST_RECALIBRATE;
				end else if (goXfer) begin
					next_state = ST_ALL_HEADS_OFF;
				end
			end
			ST_ALL_HEADS_OFF: begin
				next_state = ending ? ST_IDLE : ST_READ;
			end
			ST_READ: begin
				if (wcDone) begin
					next_state = ST_ALL_HEADS_OFF;
				end else if (trackEnd) begin
					next_state = ST_INC_HEAD;
				end else if (headerFound && isWriteFn) begin
					next_state = ST_WRITE;
				end
			end
			ST_WRITE: begin
				if (wcDone) begin
					next_state = ST_ALL_HEADS_OFF;
				end else if (trackEnd) begin
					next_state = ST_INC_HEAD;
				end
			end
			ST_INC_HEAD: begin
				next_state = lastHead ? ST_ALL_HEADS_OFF : ST_READ;
			end
			ST_SEEK: begin
				next_state = ST_IDLE;
			end
			ST_RECALIBRATE: begin
				if (!calPend && !selUw) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// read selection
	always_comb begin
		rdMux = '0;
		if (busReq.addr == ADDR_CTRL) begin
			rdMux[CTRL_FUNC_LSB +: 3] = funcReg;
			rdMux[CTRL_MNT_BIT]       = maintMode;
		end else if (busReq.addr == ADDR_UNIT) begin
			rdMux[UNITW-1:0] = unitSel;
		end else if (busReq.addr == ADDR_CYL) begin
			rdMux[CYLW-1:0] = cylAddr;
		end else if (busReq.addr == ADDR_HEAD) begin
			rdMux[HEADW-1:0] = headAddr;
		end else if (busReq.addr == ADDR_MAINT) begin
			rdMux[MSIMW-1:0] = maintSimReg;
		end else if (busReq.addr == ADDR_STATUS) begin
			rdMux[$bits(dpcs_stat_t)-1:0] = status;
		end else if (busReq.addr == ADDR_ATTN) begin
			rdMux[NUNITS-1:0] = unitAttentionBits;
		end else if (busReq.addr == ADDR_SUCYL) begin
			rdMux[CYLW-1:0] = suCyl;
		end else if (busReq.addr == ADDR_FMTGEN) begin
			rdMux[FMTW-1:0] = fmtGen;
		end else if (busReq.addr == ADDR_STATE) begin
			rdMux[2:0] = state;
		end
	end

	// software registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			funcReg     <= FN_NOP;
			maintMode   <= 1'b0;
			unitSel     <= UNIT_RST;
			cylAddr     <= CYL_RST;
			headAddr    <= HEAD_RST;
			maintSimReg <= MAINT_RST;
			busRdData   <= '0;
		end else if (ce) begin
			busRdData <= busReq.rd ? rdMux : '0;
			if (wrCtrl && (state == ST_IDLE)) begin
				funcReg   <= goFunc;
				maintMode <= busReq.wrData[CTRL_MNT_BIT];
			end
			if (wrUnit) begin
				unitSel <= busReq.wrData[UNITW-1:0];
			end
			if (wrCyl) begin
				cylAddr <= busReq.wrData[CYLW-1:0];
			end
			if (wrHead) begin
				headAddr <= busReq.wrData[HEADW-1:0];
			end
			if (wrMaint) begin
				maintSimReg <= busReq.wrData[MSIMW-1:0];
			end
		end
	end

	// sequencer state and drive commands
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state            <= ST_IDLE;
			ending           <= 1'b0;
			calPend          <= 1'b0;
			seekStart        <= '0;
			recalibrateStart <= '0;
			seekCyl          <= CYL_RST;
			headSel          <= HEAD_RST;
			headEnable       <= 1'b0;
			writeGate        <= 1'b0;
			fmtGen           <= FMT_RST;
		end else if (ce) begin
			state            <= next_state;
			seekStart        <= goSeek ? selOneHot : '0;
			recalibrateStart <= goCal ? selOneHot : '0;
			headEnable <= (next_state == ST_READ) || (next_state == ST_WRITE);
			writeGate  <= (next_state == ST_WRITE);
			if (goSeek) begin
				seekCyl <= cylAddr;
			end
			if (goCal) begin
				calPend <= 1'b1;
			end else if (selUw) begin
				calPend <= 1'b0;
			end
			if (state == ST_IDLE) begin
				ending <= 1'b0;
			end else if (next_state == ST_ALL_HEADS_OFF) begin
				ending <= (state != ST_IDLE);
			end
			if (goXfer) begin
				headSel <= headAddr;
			end else if ((state == ST_INC_HEAD) && !lastHead) begin
				headSel <= headSel + HEADW'(1);
			end
			if (state != ST_WRITE) begin
				fmtGen <= FMT_RST;
			end else if (wordTick) begin
				fmtGen <= fmtGen + FMTW'(1);
			end
		end
	end

	// status and selected-unit reporting
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			status            <= '0;
			unitAttentionBits <= '0;
			suCyl             <= CYL_RST;
		end else if (ce) begin
			unitAttentionBits       <= next_attn;
			suCyl                   <= selDrv.cyl;
			status.busy             <= (next_state != ST_IDLE);
			status.attnFlag         <= |next_attn;
			status.maintModeBit     <= maintMode;
			status.writeLockFlag    <= lockHit;
			status.readOnlyFlag     <= selDrv.readOnly;
			status.seekUnderwayFlag <= selUw;
			status.unitReadyFlag    <= selDrv.ready;
			status.unitOnlineFlag   <= selDrv.online;
			status.driveUnsafeFlag  <= selDrv.unsafe;
			status.seekTimeoutFlag  <= selTmo;
			// a new function clears the flag; it cannot start mid-transfer
			if (goReq) begin
				status.packEndFlag <= 1'b0;
			end else if (packEndSet) begin
				status.packEndFlag <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence seekGo;
		ce && goSeek;
	endsequence
	sequence calGo;
		ce && goCal;
	endsequence
	sequence headerInWrite;
		ce && (state == ST_READ) && headerFound && isWriteFn && !wcDone && !trackEnd;
	endsequence

	busy_state_a: assert property (status.busy |-> state != ST_IDLE)
		else $error("busy disagrees with sequencer state");
	seek_begin_a: assert property (seekGo |=> state == ST_SEEK && seekStart == selOneHot)
		else $error("seek did not begin");
	recalibrate_state_state_a: assert property (calGo |=> state == ST_RECALIBRATE && recalibrateStart != 0)
		else $error("recalibrate state not entered");
	header_write_a: assert property (headerInWrite |=> state == ST_WRITE && writeGate)
		else $error("write did not follow the header search");
	write_gate_a: assert property (writeGate |-> state == ST_WRITE)
		else $error("write gate outside write state");
	heads_off_a: assert property (state == ST_ALL_HEADS_OFF |-> !headEnable)
		else $error("heads enabled in clear-head state");
	head_step_a: assert property (ce && state == ST_INC_HEAD && !lastHead
		|-> !headEnable ##1 headSel == $past(headSel) + HEADW'(1))
		else $error("head not advanced");
	pack_end_a: assert property (ce && packEndSet |=> status.packEndFlag)
		else $error("end of pack not flagged");
	attn_set_a: assert property (ce && |seekDone
		|=> (unitAttentionBits & $past(seekDone)) == $past(seekDone))
		else $error("attention bit lost");
	attn_or_a: assert property (status.attnFlag == |unitAttentionBits)
		else $error("attention flag not the OR of unit bits");
	lock_cond_a: assert property ($past(ce) && status.writeLockFlag |-> $past(lockSwitch)
		&& $past(cylAddr) <= {5'h00, $past(lockCylLimit)})
		else $error("write lock-out without its conditions");
	sel_flags_a: assert property ($past(ce) && $past(rst_n) |-> suCyl == $past(selDrv.cyl)
		&& status.driveUnsafeFlag == $past(selDrv.unsafe))
		else $error("selected-unit view stale");
	fmt_step_a: assert property (ce && state == ST_WRITE && next_state == ST_WRITE && wordTick
		|=> fmtGen == $past(fmtGen) + FMTW'(1))
		else $error("format generator did not step");
endmodule

// *** dpcs_drive_model.sv ***
// behavioural model of the eight drive units behind the control
`timescale 1ns/1ps
module dpcs_drive_model (
	// clock
	input  wire logic                                       clk_sys,
	// level flags per unit {online, ready, unsafe, readOnly}, slow seek select
	input  wire logic [dpcs_pkg::NUNITS-1:0][3:0]           lv,
	input  wire logic                                       slow,
	// commands from the control
	input  wire logic [dpcs_pkg::NUNITS-1:0]                seekStart,
	input  wire logic [dpcs_pkg::NUNITS-1:0]                recalibrateStart,
	input  wire logic [dpcs_pkg::CYLW-1:0]                  seekCyl,
	// drive levels
	output dpcs_pkg::dpcs_drv_t [dpcs_pkg::NUNITS-1:0]      drvStat
);
	import dpcs_pkg::*;
	logic [NUNITS-1:0] onCyl = '1;
	logic [7:0]        cnt [NUNITS] = '{default: 8'h00};
	logic [CYLW-1:0]   cyl [NUNITS] = '{default: 8'h00};
	logic [CYLW-1:0]   tgt [NUNITS] = '{default: 8'h00};

	// heads leave the cylinder on a command and settle after a delay
	always @(posedge clk_sys) begin
		for (int u = 0; u < NUNITS; u++) begin
			if (seekStart[u] || recalibrateStart[u]) begin
				onCyl[u] <= 1'b0;
				cnt[u]   <= slow ? 8'h50 : 8'h0C;
				tgt[u]   <= seekStart[u] ? seekCyl : 8'h00;
			end else if (cnt[u] == 8'h01) begin
				onCyl[u] <= 1'b1;
				cyl[u]   <= tgt[u];
				cnt[u]   <= 8'h00;
			end else if (cnt[u] != 8'h00) begin
				cnt[u] <= cnt[u] - 8'h01;
			end
		end
	end

	always_comb begin
		for (int u = 0; u < NUNITS; u++) begin
			drvStat[u] = {lv[u], onCyl[u], cyl[u]};
		end
	end
endmodule

// *** dpcs_ctrl_bench.sv ***
// self-checking bench of the disk pack control status block
`timescale 1ns/1ps
module dpcs_ctrl_bench;
	import dpcs_pkg::*;
	logic                        clk_sys = 1'b0;
	logic                        rst_n   = 1'b0;
	dpcs_req_t                   busReq  = '0;
	logic [DW-1:0]               busRdData;
	logic [NUNITS-1:0][3:0]      lv      = '0;
	logic                        slow    = 1'b0;
	logic                        lockSwitch   = 1'b0;
	logic [LOCKW-1:0]            lockUnitSel  = 3'h0;
	logic [LOCKW-1:0]            lockCylLimit = 3'h0;
	logic [3:0]                  ev      = 4'h0;
	logic [NUNITS-1:0]           seekStart;
	logic [NUNITS-1:0]           recalibrateStart;
	logic [CYLW-1:0]             seekCyl;
	logic                        ce      = 1'b1;
	logic [HEADW-1:0]            headSel;
	logic                        headEnable;
	logic                        writeGate;
	dpcs_drv_t [NUNITS-1:0]      drvStat;
	logic [DW-1:0]               expq [$];
	logic                        rdPend  = 1'b0;
	int                          fails   = 0;
	int                          n_tests = 0;
	int                          cyc     = 0;
	integer                      seed    = 32'h5a33;

	always #5 clk_sys = ~clk_sys;

	dpcs_drive_model drv (.clk_sys(clk_sys), .lv(lv), .slow(slow), .seekStart(seekStart),
		.recalibrateStart(recalibrateStart), .seekCyl(seekCyl), .drvStat(drvStat));

	// short timeout and head count keep the run brief
	dpcs_ctrl #(.SEEK_TMO(20), .LAST_HEAD(3)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
		.busReq(busReq), .busRdData(busRdData), .drvStat(drvStat), .lockSwitch(lockSwitch),
		.lockUnitSel(lockUnitSel), .lockCylLimit(lockCylLimit), .headerFound(ev[3]),
		.wordTick(ev[2]), .trackEnd(ev[1]), .wcDone(ev[0]), .seekStart(seekStart),
		.recalibrateStart(recalibrateStart), .seekCyl(seekCyl), .headSel(headSel),
		.headEnable(headEnable), .writeGate(writeGate), .ctrlState(), .status(),
		.unitAttentionBits(), .suCyl(), .fmtGen());

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(logic [DW-1:0] got, logic [DW-1:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// read data stand only in the cycle after the strobe
	always @(posedge clk_sys) begin
		if (rdPend)
			chk(busRdData, expq.pop_front());
		rdPend <= busReq.rd;
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			test_done();
		end
	end

	task automatic wr(logic [AW-1:0] a, logic [DW-1:0] d);
		@(posedge clk_sys);
		busReq <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		busReq <= '0;
	endtask

	task automatic rdc(logic [AW-1:0] a, logic [DW-1:0] e);
		@(posedge clk_sys);
		busReq <= '{a, '0, 1'b0, 1'b1};
		expq.push_back(e);
		@(posedge clk_sys);
		busReq <= '0;
	endtask

	task automatic pz(logic [3:0] m);
		@(posedge clk_sys);
		ev <= m;
		@(posedge clk_sys);
		ev <= 4'h0;
	endtask

	task automatic w(int n);
		repeat (n) @(posedge clk_sys);
	endtask

	function automatic logic [DW-1:0] go(dpcs_func_t f);
		return DW'(f) | (DW'(1) << CTRL_GO_BIT);
	endfunction

	// status word of unit u: busy, attention, underway, timeout, end of pack
	function automatic logic [DW-1:0] stw(int u, logic b, logic a, logic s, logic t, logic p);
		dpcs_stat_t e;
		e = '0;
		{e.busy, e.attnFlag, e.seekUnderwayFlag, e.seekTimeoutFlag, e.packEndFlag} = {b, a, s, t, p};
		{e.unitOnlineFlag, e.unitReadyFlag, e.driveUnsafeFlag, e.readOnlyFlag} = lv[u];
		return DW'(e);
	endfunction

	logic [11:0] lk [4] = '{12'h8AB, 12'h8AC, 12'h9AA, 12'h0AA};
	dpcs_stat_t  ms;

	initial begin
		for (int u = 1; u < NUNITS; u++)
			lv[u] = 4'($random(seed));
		lv[0] = 4'hC;
		w(12);
		rst_n <= 1'b1;
		for (int u = 0; u < NUNITS; u++) begin
			wr(ADDR_UNIT, DW'(u));
			rdc(ADDR_STATUS, stw(u, 0, 0, 0, 0, 0));
		end
		wr(ADDR_UNIT, 18'h00000);
		$display("test unit flags done");
		// {switch, unit, limit, cylinder} and the expected lock flag
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			{lockSwitch, lockUnitSel, lockCylLimit} <= lk[i][11:5];
			wr(ADDR_CYL, DW'(lk[i][4:1]));
			ms = dpcs_stat_t'(stw(0, 0, 0, 0, 0, 0));
			ms.writeLockFlag = lk[i][0];
			rdc(ADDR_STATUS, DW'(ms));
		end
		lockSwitch <= 1'b0;
		$display("test lock-out done");
		wr(ADDR_HEAD, 18'h00002);
		wr(ADDR_CTRL, go(FN_READ));
		w(2);
		rdc(ADDR_STATE, DW'(ST_READ));
		pz(4'h2);
		w(2);
		rdc(ADDR_STATE, DW'(ST_READ));
		@(negedge clk_sys);
		chk(DW'({headEnable, writeGate, headSel}), 18'h00043);
		pz(4'h2);
		w(4);
		rdc(ADDR_STATE, DW'(ST_IDLE));
		rdc(ADDR_STATUS, stw(0, 0, 0, 0, 0, 1));
		wr(ADDR_HEAD, 18'h00000);
		wr(ADDR_CTRL, go(FN_WRITE));
		w(2);
		rdc(ADDR_STATE, DW'(ST_READ));
		pz(4'h8);
		w(2);
		rdc(ADDR_STATE, DW'(ST_WRITE));
		@(negedge clk_sys);
		chk(DW'({headEnable, writeGate, headSel}), 18'h00060);
		repeat (5) pz(4'h4);
		rdc(ADDR_FMTGEN, 18'h00005);
		// a frozen enable must swallow a word tick
		ce <= 1'b0;
		pz(4'h4);
		ce <= 1'b1;
		rdc(ADDR_FMTGEN, 18'h00005);
		rdc(ADDR_STATUS, stw(0, 1, 0, 0, 0, 0));
		pz(4'h1);
		w(4);
		rdc(ADDR_FMTGEN, 18'h00000);
		rdc(ADDR_STATE, DW'(ST_IDLE));
		@(negedge clk_sys);
		chk(DW'({headEnable, writeGate, headSel}), 18'h00000);
		$display("test transfers done");
		wr(ADDR_UNIT, 18'h00001);
		wr(ADDR_CYL, 18'h0005A);
		wr(ADDR_CTRL, go(FN_SEEK));
		w(2);
		rdc(ADDR_STATUS, stw(1, 0, 0, 1, 0, 0));
		w(20);
		rdc(ADDR_STATUS, stw(1, 0, 1, 0, 0, 0));
		rdc(ADDR_ATTN, 18'h00002);
		rdc(ADDR_SUCYL, 18'h0005A);
		wr(ADDR_CTRL, go(FN_RECALIBRATE));
		rdc(ADDR_STATE, DW'(ST_RECALIBRATE));
		w(25);
		rdc(ADDR_SUCYL, 18'h00000);
		wr(ADDR_ATTN, 18'h000FF);
		rdc(ADDR_ATTN, 18'h00000);
		$display("test seek done");
		wr(ADDR_MAINT, 18'h0000B);
		wr(ADDR_CTRL, DW'(1) << CTRL_MNT_BIT);
		w(2);
		ms = '0;
		{ms.maintModeBit, ms.unitOnlineFlag, ms.unitReadyFlag, ms.readOnlyFlag} = 4'hF;
		rdc(ADDR_STATUS, DW'(ms));
		// simulated read-only drive refuses a format and leaves maintenance mode
		wr(ADDR_CTRL, go(FN_FORMAT));
		rdc(ADDR_STATE, DW'(ST_IDLE));
		rdc(8'h3C, 18'h00000);
		$display("test maintenance done");
		slow <= 1'b1;
		wr(ADDR_CTRL, go(FN_SEEK));
		w(35);
		rdc(ADDR_STATUS, stw(1, 0, 0, 0, 1, 0));
		$display("test seek timeout done");
		w(3);
		test_done();
	end
endmodule
